/* dv/remote_image_upgrade_control_tb.sv */
// Purpose: Self-checking bench for the remote image upgrade control
// Assumes: pclk 10 MHz; APB master waits for pready, never a fixed count
// Notes: Watchdog limit cut to 60 cycles by a register write
`timescale 1ns/10ps
module remote_image_upgrade_control_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, d, upgrade_serial_out, load_start, load_image, user_mode;
  logic upgrade_clock, upgrade_serial_in, shift_or_load_ctrl, capture_or_update_ctrl;
  logic watchdog_restart_n, internal_reload_request_n;
  logic external_status_n = 1'b1, external_config_n = 1'b1, crc_error = 1'b0;
  logic image_select_pin = 1'b1, load_done = 1'b0;
  logic [40:0] sv;
  logic [38:0] got;
  int mismatches = 0, n_checks = 0, cyc = 0;
  remote_image_upgrade_control dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .upgrade_clock, .upgrade_serial_in,
    .shift_or_load_ctrl, .capture_or_update_ctrl, .watchdog_restart_n,
    .internal_reload_request_n, .external_status_n, .external_config_n, .crc_error,
    .image_select_pin, .load_done, .upgrade_serial_out, .load_start, .load_image, .user_mode);
  user_logic_model user_u (.pclk, .upgrade_serial_out, .upgrade_clock, .upgrade_serial_in,
    .shift_or_load_ctrl, .capture_or_update_ctrl, .watchdog_restart_n,
    .internal_reload_request_n);
  always #50 pclk = ~pclk;
  task automatic finish_test();
    $display("Checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle limit here; pready ends this wait, or else the bench timeout
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sources are levels, so they are dropped once the load has begun
  task automatic wait_load(input logic img);
    int n = 0;
    while (load_start !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 300) chk(32'h0, 32'h1, "no load start");
    external_config_n <= 1'b1;
    crc_error <= 1'b0;
    user_u.reload(1'b1);
    chk({31'h0, load_image}, {31'h0, img}, "load image");
    load_done <= 1'b1;
    @(posedge pclk);
    load_done <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({31'h0, user_mode}, 32'h1, "user mode");
  endtask
  task automatic no_load(input int n);
    int hits = 0;
    repeat (n) begin
      @(posedge pclk);
      hits += int'(load_start !== 1'b0);
    end
    chk(hits, 32'h0, "unexpected load");
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_load(1'b1);
    $display("Test power-up done");
    apb(1'b0, rsu_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h5, "ctrl reset");
    apb(1'b0, rsu_pkg::ADDR_WDVAL, 32'h0);
    chk(rd, 32'h0000_0fff, "wdval reset");
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped error");
    apb(1'b1, rsu_pkg::ADDR_CTRL, 32'h1);
    $display("Test registers done");
    sv = 41'h0;
    sv[40:39] = 2'b11;
    sv[rsu_pkg::IR_OVR_BIT] = 1'b1;
    for (int i = 0; i < 41; i++) user_u.ucycle(1'b1, 1'b0, sv[i], d);
    user_u.release_line();
    user_u.ucycle(1'b0, 1'b0, 1'b0, d);
    apb(1'b0, rsu_pkg::ADDR_INREG, 32'h0);
    chk(rd, 32'h0000_1000, "input reg");
    user_u.ucycle(1'b0, 1'b1, 1'b0, d);
    for (int i = 0; i < 39; i++) begin
      user_u.ucycle(1'b1, 1'b1, 1'b0, d);
      got[i] = d;
    end
    chk(got[31:0], 32'h0000_1000, "readback low");
    chk({25'h0, got[38:32]}, 32'h0, "readback high");
    $display("Test upgrade port done");
    user_u.reload(1'b0);
    wait_load(1'b0);
    $display("Test override reload done");
    apb(1'b1, rsu_pkg::ADDR_WDVAL, 32'h0000003c);
    apb(1'b1, rsu_pkg::ADDR_CTRL, 32'h5);
    repeat (4) begin
      user_u.wd_restart();
      no_load(25);
    end
    wait_load(1'b1);
    apb(1'b0, rsu_pkg::ADDR_PREV1, 32'h0);
    chk(rd, {rsu_pkg::CAUSE_WD, 2'h0, rsu_pkg::ST_LOAD0, 22'h0}, "revert cause");
    apb(1'b0, rsu_pkg::ADDR_STATUS, 32'h0);
    chk({28'h0, rd[3:0]}, {28'h0, rsu_pkg::ST_USER_REV}, "revert state");
    no_load(200);
    apb(1'b0, rsu_pkg::ADDR_STATUS, 32'h0);
    chk({28'h0, rd[3:0]}, {28'h0, rsu_pkg::ST_WAIT}, "wait state");
    // Watchdog off first, so the recorded cause stays put while shifting
    apb(1'b1, rsu_pkg::ADDR_CTRL, 32'h1);
    sv = 41'h0;
    sv[39] = 1'b1;
    for (int i = 0; i < 41; i++) user_u.ucycle(1'b1, 1'b0, sv[i], d);
    user_u.ucycle(1'b0, 1'b1, 1'b0, d);
    for (int i = 0; i < 32; i++) begin
      user_u.ucycle(1'b1, 1'b0, 1'b0, d);
      got[i] = d;
    end
    chk(got[31:0], {rsu_pkg::CAUSE_WD, 2'h0, rsu_pkg::ST_REV1, 22'h0}, "prev via port");
    $display("Test watchdog revert done");
    apb(1'b1, rsu_pkg::ADDR_CTRL, 32'h0);
    user_u.reload(1'b0);
    no_load(30);
    user_u.reload(1'b1);
    apb(1'b1, rsu_pkg::ADDR_CTRL, 32'h1);
    external_config_n <= 1'b0;
    wait_load(1'b0);
    $display("Test reload sources done");
    crc_error <= 1'b1;
    wait_load(1'b1);
    apb(1'b1, rsu_pkg::ADDR_CTRL, 32'h3);
    crc_error <= 1'b1;
    wait_load(1'b0);
    external_config_n <= 1'b0;
    crc_error <= 1'b1;
    wait_load(1'b0);
    apb(1'b0, rsu_pkg::ADDR_PREV1, 32'h0);
    chk(rd, {rsu_pkg::CAUSE_CFG, 2'h0, rsu_pkg::ST_LOAD0, 22'h0}, "cause priority");
    $display("Test error sources done");
    finish_test();
  end
endmodule // remote_image_upgrade_control_tb

/* dv/user_logic_model.sv */
// Purpose: Fabric-side user logic driving the serial upgrade port
// Assumes: pclk period 100 ns; upgrade clock period 800 ns, still between frames
// Notes: A released data line shows the inverse of its last value
`timescale 1ns/10ps
module user_logic_model (
  input wire logic pclk,
  input wire logic upgrade_serial_out,
  output logic upgrade_clock = 1'b0,
  output logic upgrade_serial_in = 1'b0,
  output logic shift_or_load_ctrl = 1'b0,
  output logic capture_or_update_ctrl = 1'b1,
  output logic watchdog_restart_n = 1'b1,
  output logic internal_reload_request_n = 1'b1
);
  // One upgrade clock period; dout is the port output just before the rise
  task automatic ucycle(input logic shf, input logic capt, input logic din,
                        output logic dout);
    @(posedge pclk);
    shift_or_load_ctrl <= shf;
    capture_or_update_ctrl <= capt;
    upgrade_serial_in <= din;
    // Three cycles of setup keep the period at 800 ns
    repeat (3) @(posedge pclk);
    dout = upgrade_serial_out;
    upgrade_clock <= 1'b1;
    repeat (4) @(posedge pclk);
    upgrade_clock <= 1'b0;
  endtask
  task automatic release_line();
    @(posedge pclk);
    upgrade_serial_in <= ~upgrade_serial_in;
  endtask
  // Held low a whole number of cycles covering the minimum width
  task automatic wd_restart();
    @(posedge pclk);
    watchdog_restart_n <= 1'b0;
    repeat (rsu_pkg::WD_RESTART_MIN_CYC) @(posedge pclk);
    watchdog_restart_n <= 1'b1;
  endtask
  task automatic reload(input logic v);
    @(posedge pclk);
    internal_reload_request_n <= v;
  endtask
endmodule // user_logic_model

/* logic/remote_image_upgrade_control.sv */
// Purpose: Dual image selection, revert and serial upgrade port control
// Assumes: Pins are asynchronous to pclk; upgrade clock far slower than pclk
// Notes: Registers on APB, zero wait state, unmapped addresses give pslverr
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
// Summary of operation
// - Two images, 0 and 1; each load picks exactly one of them.
// - Upgrade feature enabled by default out of reset.
// - Power-up picks image from select pin; later loads may use input register.
// - CRC error or watchdog time-out loads the other image.
// - After revert, user logic can read cause and failed image.
// - Second error waits for a reload source, unless auto restart is on.
// - Status low, config low or internal reload low start a reload.
// - Internal reload request only acts while upgrade is enabled.
// - Falling edge of watchdog restart input clears the watchdog.
// - Upgrade clock domain registers work only in user mode when enabled.
// - Serial data taken into shift chain on each upgrade clock rise in shift mode.
// - Shift mode drives shift chain bits out, one per upgrade clock rise.
// - Both controls low copy shift chain into input register.
// - Shift low, capture high loads shift chain from state source.
// - Shift high ignores capture control and shifts every rise.
// - Input bit 13 picks next image only when bit 12 is set.
// - Ties in reload cause keep only the highest bit.
// - Update moves shift chain into input register for next reload.
module remote_image_upgrade_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic upgrade_clock,
  input wire logic upgrade_serial_in,
  input wire logic shift_or_load_ctrl,
  input wire logic capture_or_update_ctrl,
  input wire logic watchdog_restart_n,
  input wire logic internal_reload_request_n,
  input wire logic external_status_n,
  input wire logic external_config_n,
  input wire logic crc_error,
  input wire logic image_select_pin,
  input wire logic load_done,
  output logic upgrade_serial_out,
  output logic load_start,
  output logic load_image,
  output logic user_mode
);
  upgrade_link_if link ();

  logic [rsu_pkg::SY_N-1:0] pin_raw;
  logic [rsu_pkg::SY_N-1:0] sy1_q;
  logic [rsu_pkg::SY_N-1:0] sy2_q;
  logic [rsu_pkg::SY_N-1:0] sy3_q;
  logic [2:0] ctrl_q;
  logic [rsu_pkg::WD_W-1:0] wdval_q;
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  rsu_pkg::msm_t state_q;
  logic [3:0] loaded_q;
  logic [1:0] fill_q;
  logic cur_image_q;
  logic load_start_q;
  logic load_image_q;
  logic user_mode_q;
  logic serial_out_q;
  logic [rsu_pkg::PS_W-1:0] prev1_q;
  logic [rsu_pkg::PS_W-1:0] prev2_q;
  logic wd_timeout;
  logic wd_run;
  logic wd_restart;
  logic up_en;
  logic in_user;
  logic ev_cfg;
  logic ev_crc;
  logic ev_sta;
  logic ext_req;
  logic err_req;
  logic chosen_image;
  logic [3:0] cause;
  logic done_rise;
  logic [31:0] rd_word;
  logic rd_hit;

  assign pin_raw = {load_done, image_select_pin, crc_error, external_config_n,
                    external_status_n, internal_reload_request_n, watchdog_restart_n,
                    capture_or_update_ctrl, shift_or_load_ctrl, upgrade_serial_in,
                    upgrade_clock};

  // Third stage keeps data from before the clock edge was seen
  genvar gi;
  generate
    for (gi = 0; gi < rsu_pkg::SY_N; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sy1_q[gi] <= 1'b1;
          sy2_q[gi] <= 1'b1;
          sy3_q[gi] <= 1'b1;
        end else begin
          sy1_q[gi] <= pin_raw[gi];
          sy2_q[gi] <= sy1_q[gi];
          sy3_q[gi] <= sy2_q[gi];
        end
      end
    end
  endgenerate

  assign up_en = ctrl_q[rsu_pkg::CTRL_EN_BIT];
  assign in_user = (state_q == rsu_pkg::ST_USER) || (state_q == rsu_pkg::ST_USER_REV) ||
                   (state_q == rsu_pkg::ST_WAIT);
  assign done_rise = sy2_q[rsu_pkg::SY_DONE] && !sy3_q[rsu_pkg::SY_DONE];

  // Upgrade port samples data from the cycle before the edge was seen
  assign link.step = sy2_q[rsu_pkg::SY_CLK] && !sy3_q[rsu_pkg::SY_CLK]
                     && user_mode_q && up_en;
  assign link.shift_mode = sy3_q[rsu_pkg::SY_SHF];
  assign link.capt_mode = sy3_q[rsu_pkg::SY_CAP];
  assign link.serial_in = sy3_q[rsu_pkg::SY_DIN];
  assign link.cur_state = {5'h00, loaded_q, ctrl_q[rsu_pkg::CTRL_WDEN_BIT], wdval_q};
  assign link.prev1 = prev1_q;
  assign link.prev2 = prev2_q;

  upgrade_shift_chain u_chain (
    .pclk(pclk),
    .presetn(presetn),
    .link(link)
  );

  assign wd_run = user_mode_q && up_en && ctrl_q[rsu_pkg::CTRL_WDEN_BIT];
  assign wd_restart = sy3_q[rsu_pkg::SY_WDR] && !sy2_q[rsu_pkg::SY_WDR];

  upgrade_watchdog u_wd (
    .pclk(pclk),
    .presetn(presetn),
    .run(wd_run),
    .restart(wd_restart),
    .limit(wdval_q),
    .timeout(wd_timeout)
  );

  // Reload sources are levels; a held request keeps reloading
  assign ev_cfg = !sy2_q[rsu_pkg::SY_CFG] || (!sy2_q[rsu_pkg::SY_RLD] && up_en);
  assign ev_sta = !sy2_q[rsu_pkg::SY_STA];
  assign ev_crc = sy2_q[rsu_pkg::SY_CRC] && up_en;
  assign ext_req = ev_cfg || ev_sta;
  assign err_req = ev_crc || (wd_timeout && up_en);
  assign chosen_image = link.in_reg[rsu_pkg::IR_OVR_BIT] ? link.in_reg[rsu_pkg::IR_SEL_BIT]
                        : sy2_q[rsu_pkg::SY_SEL];

  always_comb begin
    if (ev_cfg) begin
      cause = rsu_pkg::CAUSE_CFG;
    end else if (ev_crc) begin
      cause = rsu_pkg::CAUSE_CRC;
    end else if (ev_sta) begin
      cause = rsu_pkg::CAUSE_STA;
    end else begin
      cause = rsu_pkg::CAUSE_WD;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev1_q <= '0;
      prev2_q <= '0;
    end else if (in_user && (ext_req || err_req)) begin
      prev2_q <= prev1_q;
      prev1_q <= {cause, 2'h0, loaded_q, 22'h000000};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= rsu_pkg::ST_IDLE;
      loaded_q <= 4'h0;
      fill_q <= 2'h0;
      cur_image_q <= 1'b0;
      load_start_q <= 1'b0;
      load_image_q <= 1'b0;
      user_mode_q <= 1'b0;
    end else begin
      load_start_q <= 1'b0;
      case (state_q)
        rsu_pkg::ST_IDLE: begin
          // Wait for the pin synchronisers to hold real levels
          if (fill_q == rsu_pkg::SYNC_FILL) begin
            load_start_q <= 1'b1;
            load_image_q <= sy2_q[rsu_pkg::SY_SEL];
            cur_image_q <= sy2_q[rsu_pkg::SY_SEL];
            state_q <= sy2_q[rsu_pkg::SY_SEL] ? rsu_pkg::ST_LOAD1 : rsu_pkg::ST_LOAD0;
            loaded_q <= sy2_q[rsu_pkg::SY_SEL] ? rsu_pkg::ST_LOAD1 : rsu_pkg::ST_LOAD0;
          end else begin
            fill_q <= fill_q + 2'h1;
          end
        end
        rsu_pkg::ST_LOAD0, rsu_pkg::ST_LOAD1: begin
          if (done_rise) begin
            state_q <= rsu_pkg::ST_USER;
            user_mode_q <= 1'b1;
          end
        end
        rsu_pkg::ST_REV0, rsu_pkg::ST_REV1: begin
          if (done_rise) begin
            state_q <= rsu_pkg::ST_USER_REV;
            user_mode_q <= 1'b1;
          end
        end
        default: begin
          if (ext_req || (err_req && state_q == rsu_pkg::ST_USER_REV
                          && ctrl_q[rsu_pkg::CTRL_AUTO_BIT])) begin
            load_start_q <= 1'b1;
            load_image_q <= chosen_image;
            cur_image_q <= chosen_image;
            user_mode_q <= 1'b0;
            state_q <= chosen_image ? rsu_pkg::ST_LOAD1 : rsu_pkg::ST_LOAD0;
            loaded_q <= chosen_image ? rsu_pkg::ST_LOAD1 : rsu_pkg::ST_LOAD0;
          end else if (err_req && state_q == rsu_pkg::ST_USER) begin
            load_start_q <= 1'b1;
            load_image_q <= !cur_image_q;
            cur_image_q <= !cur_image_q;
            user_mode_q <= 1'b0;
            state_q <= cur_image_q ? rsu_pkg::ST_REV0 : rsu_pkg::ST_REV1;
            loaded_q <= cur_image_q ? rsu_pkg::ST_REV0 : rsu_pkg::ST_REV1;
          end else if (err_req && state_q == rsu_pkg::ST_USER_REV) begin
            state_q <= rsu_pkg::ST_WAIT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out_q <= 1'b0;
    end else begin
      serial_out_q <= link.serial_bit;
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    if (paddr == rsu_pkg::ADDR_CTRL) begin
      rd_word = {29'h0, ctrl_q};
    end else if (paddr == rsu_pkg::ADDR_WDVAL) begin
      rd_word = {3'h0, wdval_q};
    end else if (paddr == rsu_pkg::ADDR_STATUS) begin
      rd_word = {20'h0, loaded_q, 2'h0, user_mode_q, cur_image_q, state_q};
    end else if (paddr == rsu_pkg::ADDR_INREG) begin
      rd_word = link.in_reg[31:0];
    end else if (paddr == rsu_pkg::ADDR_PREV1) begin
      rd_word = prev1_q;
    end else if (paddr == rsu_pkg::ADDR_PREV2) begin
      rd_word = prev2_q;
    end else begin
      rd_word = 32'h0;
      rd_hit = 1'b0;
    end
  end

  // Answer is prepared in setup so every bus output is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pready_q <= 1'b1;
      prdata_q <= pwrite ? 32'h0 : rd_word;
      pslverr_q <= !rd_hit;
    end else begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0;
      pslverr_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= rsu_pkg::CTRL_RST;
      wdval_q <= rsu_pkg::WD_VAL_RST;
    end else if (psel && penable && pready_q && pwrite) begin
      if (paddr == rsu_pkg::ADDR_CTRL) begin
        ctrl_q <= pwdata[2:0];
      end else if (paddr == rsu_pkg::ADDR_WDVAL) begin
        wdval_q <= pwdata[28:0];
      end
    end
  end

  assign pready = pready_q;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;
  assign upgrade_serial_out = serial_out_q;
  assign load_start = load_start_q;
  assign load_image = load_image_q;
  assign user_mode = user_mode_q;

  a_revert_other: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == rsu_pkg::ST_USER && err_req && !ext_req
    |=> load_start_q && load_image_q != $past(cur_image_q))
    else $error("error did not load the other image");
  a_second_wait: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == rsu_pkg::ST_USER_REV && err_req && !ext_req && !ctrl_q[1]
    |=> state_q == rsu_pkg::ST_WAIT && !load_start_q)
    else $error("second error did not wait");
  a_reload_gated: assert property (@(posedge pclk) disable iff (!presetn)
    in_user && !up_en && sy2_q[rsu_pkg::SY_CFG] && sy2_q[rsu_pkg::SY_STA]
    |=> !load_start_q)
    else $error("reload taken while upgrade disabled");
  a_cause_priority: assert property (@(posedge pclk) disable iff (!presetn)
    in_user && ev_cfg && ev_crc |=> prev1_q[31:28] == 4'h8)
    else $error("reload cause kept a lower source");
  a_load_single: assert property (@(posedge pclk) disable iff (!presetn)
    load_start_q |=> !load_start_q ##1 !load_start_q)
    else $error("load start longer than one pulse");
  a_override_pick: assert property (@(posedge pclk) disable iff (!presetn)
    in_user && ev_cfg && link.in_reg[12]
    |=> load_start_q && load_image_q == $past(link.in_reg[13]))
    else $error("override bit ignored on reload");
  a_step_gated: assert property (@(posedge pclk) disable iff (!presetn)
    !user_mode_q |-> !link.step)
    else $error("upgrade port active outside user mode");
endmodule // remote_image_upgrade_control

/* logic/rsu_pkg.sv */
// Purpose: Shared constants and types for the remote image upgrade control
// Assumes: 10 MHz pclk, APB register access
// Notes: Offsets are byte addresses of 32-bit words
package rsu_pkg;
  localparam int SR_W = 41;
  localparam int IR_W = 39;
  localparam int PS_W = 32;
  localparam int WD_W = 29;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_WDVAL = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_INREG = 12'h00c;
  localparam logic [11:0] ADDR_PREV1 = 12'h010;
  localparam logic [11:0] ADDR_PREV2 = 12'h014;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int CTRL_WDEN_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h5;
  localparam logic [WD_W-1:0] WD_VAL_RST = 29'h0000fff;
  localparam int IR_SEL_BIT = 13;
  localparam int IR_OVR_BIT = 12;
  localparam logic [1:0] SYNC_FILL = 2'h3;
  localparam int CLK_NS = 100;
  localparam int WD_RESTART_MIN_NS = 250;
  localparam int WD_RESTART_MIN_CYC = (WD_RESTART_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int SY_CLK = 0;
  localparam int SY_DIN = 1;
  localparam int SY_SHF = 2;
  localparam int SY_CAP = 3;
  localparam int SY_WDR = 4;
  localparam int SY_RLD = 5;
  localparam int SY_STA = 6;
  localparam int SY_CFG = 7;
  localparam int SY_CRC = 8;
  localparam int SY_SEL = 9;
  localparam int SY_DONE = 10;
  localparam int SY_N = 11;
  localparam logic [3:0] CAUSE_CFG = 4'h8;
  localparam logic [3:0] CAUSE_CRC = 4'h4;
  localparam logic [3:0] CAUSE_STA = 4'h2;
  localparam logic [3:0] CAUSE_WD = 4'h1;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_LOAD0 = 4'b0010,
    ST_REV1 = 4'b0011,
    ST_LOAD1 = 4'b0100,
    ST_REV0 = 4'b0101,
    ST_USER = 4'b1000,
    ST_USER_REV = 4'b1001,
    ST_WAIT = 4'b1010
  } msm_t;
endpackage

/* logic/upgrade_link_if.sv */
// Purpose: Carrier between the controller and the serial shift chain
// Assumes: All signals live in the pclk domain
// Notes: step is a one-cycle enable per qualified upgrade clock edge
`timescale 1ns/10ps
interface upgrade_link_if;
  logic step;
  logic shift_mode;
  logic capt_mode;
  logic serial_in;
  logic serial_bit;
  logic [rsu_pkg::IR_W-1:0] cur_state;
  logic [rsu_pkg::PS_W-1:0] prev1;
  logic [rsu_pkg::PS_W-1:0] prev2;
  logic [rsu_pkg::IR_W-1:0] in_reg;
  modport chain (input step, input shift_mode, input capt_mode, input serial_in,
                 input cur_state, input prev1, input prev2,
                 output serial_bit, output in_reg);
  modport ctrl (output step, output shift_mode, output capt_mode, output serial_in,
                output cur_state, output prev1, output prev2,
                input serial_bit, input in_reg);
endinterface

/* logic/upgrade_shift_chain.sv */
// Purpose: Shift, capture and update registers of the upgrade port
// Assumes: step already gated by user mode and upgrade enable
// Notes: Bits 40:39 of the shift chain pick the capture source
`timescale 1ns/10ps
module upgrade_shift_chain (
  input wire logic pclk,
  input wire logic presetn,
  upgrade_link_if.chain link
);
  logic [rsu_pkg::SR_W-1:0] sr_q;
  logic [rsu_pkg::IR_W-1:0] ir_q;
  logic [rsu_pkg::IR_W-1:0] capt_src;

  always_comb begin
    case (sr_q[40:39])
      2'b00: capt_src = link.cur_state;
      2'b01: capt_src = {7'h00, link.prev1};
      2'b10: capt_src = {7'h00, link.prev2};
      default: capt_src = ir_q;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sr_q <= '0;
    end else if (link.step) begin
      if (link.shift_mode) begin
        sr_q <= {link.serial_in, sr_q[40:1]};
      end else if (link.capt_mode) begin
        sr_q[38:0] <= capt_src;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_q <= '0;
    end else if (link.step && !link.shift_mode && !link.capt_mode) begin
      ir_q <= sr_q[38:0];
    end
  end

  assign link.serial_bit = sr_q[0];
  assign link.in_reg = ir_q;

  a_shift_msb_in: assert property (@(posedge pclk) disable iff (!presetn)
    link.step && link.shift_mode |=> sr_q[40] == $past(link.serial_in))
    else $error("serial input did not enter at the top bit");
  a_shift_ignores_capt: assert property (@(posedge pclk) disable iff (!presetn)
    link.step && link.shift_mode |=> sr_q[39:0] == $past(sr_q[40:1]))
    else $error("shift did not advance one bit");
  a_update_copies: assert property (@(posedge pclk) disable iff (!presetn)
    link.step && !link.shift_mode && !link.capt_mode |=> ir_q == $past(sr_q[38:0]))
    else $error("update did not copy the shift chain");
  a_capture_current: assert property (@(posedge pclk) disable iff (!presetn)
    link.step && !link.shift_mode && link.capt_mode && sr_q[40:39] == 2'b00
    |=> sr_q[38:0] == $past(link.cur_state))
    else $error("capture did not load current state");
  a_input_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !link.step |=> $stable(ir_q))
    else $error("input register changed without update");
endmodule // upgrade_shift_chain

/* logic/upgrade_watchdog.sv */
// Purpose: User watchdog counter for the running image
// Assumes: restart is a one-cycle pulse on pclk
// Notes: Counts pclk cycles up to the programmed time-out value
`timescale 1ns/10ps
module upgrade_watchdog (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic restart,
  input wire logic [rsu_pkg::WD_W-1:0] limit,
  output logic timeout
);
  logic [rsu_pkg::WD_W-1:0] cnt_q;
  logic timeout_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (!run || restart || timeout_q) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 29'h0000001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_q <= 1'b0;
    end else begin
      timeout_q <= run && !restart && !timeout_q && (cnt_q >= limit);
    end
  end

  assign timeout = timeout_q;

  a_restart_clears: assert property (@(posedge pclk) disable iff (!presetn)
    restart |=> cnt_q == '0 && !timeout_q)
    else $error("watchdog restart did not clear the count");
endmodule // upgrade_watchdog
